// >>> shared/tme_consts.vh
`ifndef TME_CONSTS_VH
`define TME_CONSTS_VH
// ****************************************************************
// Register offsets on the bus (byte addresses)
// ****************************************************************
`define TME_OFS_CFG1      6'h00
`define TME_OFS_CFG2      6'h04
`define TME_OFS_RET       6'h08
`define TME_OFS_STATUS    6'h0C
`define TME_OFS_MSW       6'h10
`define TME_OFS_IRQ_STAT  6'h14
`define TME_OFS_IRQ_MASK  6'h18
`define TME_OFS_VEC       6'h1C
// ****************************************************************
// Field positions
// ****************************************************************
`define TME_CFG1_FLASH    20
`define TME_CFG2_SWT      12
`define TME_CFG2_WLK_LO   16
`define TME_CFG2_WLK_HI   18
`define TME_ST_KEY        12
`define TME_ST_DI         13
`define TME_ST_WAY        14
`define TME_ST_SL         15
// Machine state word bit positions (bit 0 = least significant)
`define TME_MSW_LE        0
`define TME_MSW_RI        1
`define TME_MSW_DR        4
`define TME_MSW_IR        5
`define TME_MSW_IP        6
`define TME_MSW_FE1       8
`define TME_MSW_BE        9
`define TME_MSW_SE        10
`define TME_MSW_FE0       11
`define TME_MSW_ME        12
`define TME_MSW_FP        13
`define TME_MSW_PR        14
`define TME_MSW_EE        15
`define TME_MSW_ILE       16
`define TME_MSW_TGPR      17
`define TME_MSW_POW       18
// Bits cleared on miss entry (also the TGPR bit 17)
`define TME_MSW_CLR_MASK  32'h0006_EF32
// ****************************************************************
// Vectors and bases
// ****************************************************************
`define TME_VEC_IMISS     32'h0000_1000
`define TME_VEC_LMISS     32'h0000_1100
`define TME_VEC_SMISS     32'h0000_1200
`define TME_BASE_LOW      32'h0000_0000
`define TME_BASE_HIGH     32'hFFF0_0000
// ****************************************************************
// Reset values and cache geometry
// ****************************************************************
`define TME_ZERO32        32'h0000_0000
`define TME_MSW_RST       32'h0000_0040
`define TME_WAYS          8
`define TME_WLK_ALL       3'h7
`define TME_ONE8          8'h01
`define TME_ZERO8         8'h00
`endif

// >>> rtl/tme_way_lock.v
`include "tme_consts.vh"
// ****************************************************************
// Way-lock decode: field value n below 7 locks ways 0..n-1
// ****************************************************************
module tme_way_lock (
  input  wire [2:0] lock_field_i,
  output wire [7:0] lock_mask_o
);
  genvar g;
  generate
    for (g = 0; g < `TME_WAYS; g = g + 1) begin : g_way
      // Reserved code 7 locks nothing
      assign lock_mask_o[g] = (lock_field_i != `TME_WLK_ALL) && (g < lock_field_i);
    end
  endgenerate
endmodule

// >>> rtl/tme_miss_entry.v
`include "tme_consts.vh"
module tme_miss_entry (
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Translation lookup results from the core
  input  wire        imiss_i,
  input  wire        dmiss_i,
  input  wire        dstore_i,
  input  wire        dchg_i,
  input  wire [31:0] next_pc_i,
  input  wire [3:0]  cond_zero_i,
  input  wire        key_i,
  input  wire        lru_way_i,
  // Instruction cache invalidate request
  input  wire        blk_inv_i,
  input  wire [2:0]  blk_way_i,
  // Core-facing outputs
  output reg         hw_search_o,
  output reg         redirect_o,
  output reg  [31:0] redirect_pc_o,
  output reg         flash_inv_o,
  output reg         blk_inv_o,
  output reg  [2:0]  blk_inv_way_o,
  output reg  [7:0]  way_lock_o,
  output reg         irq_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  reg  [31:0] cfg1_q;
  reg  [31:0] cfg2_q;
  reg  [31:0] ret_q;
  reg  [31:0] stat_q;
  reg  [31:0] msw_q;
  reg  [2:0]  ist_q;
  reg  [2:0]  imask_q;
  reg  [31:0] vec_q;
  reg         flash_prev_q;
  wire [7:0]  lock_mask;

  // Byte-lane merge for writes
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    begin
      // Each enabled lane takes the new byte, the others keep theirs
      wmerge[31:24] = sel[3] ? nw[31:24] : old[31:24];
      wmerge[23:16] = sel[2] ? nw[23:16] : old[23:16];
      wmerge[15:8]  = sel[1] ? nw[15:8]  : old[15:8];
      wmerge[7:0]   = sel[0] ? nw[7:0]   : old[7:0];
    end
  endfunction

  // Register select for one bus offset
  function adr_hit;
    input [5:0] adr;
    input [5:0] ofs;
    begin
      adr_hit = (adr == ofs);
    end
  endfunction

  // ****************************************************************
  // Way-lock decode
  // ****************************************************************
  tme_way_lock u_lock (
    .lock_field_i (cfg2_q[`TME_CFG2_WLK_HI:`TME_CFG2_WLK_LO]),
    .lock_mask_o  (lock_mask)
  );

  // ****************************************************************
  // Miss classification
  // ****************************************************************
  wire swt_on   = cfg2_q[`TME_CFG2_SWT];
  wire i_take   = swt_on & imiss_i;
  wire s_take   = swt_on & dstore_i & (dmiss_i | dchg_i);
  wire l_take   = swt_on & dmiss_i & ~dstore_i;
  wire any_take = i_take | s_take | l_take;
  // A data miss that loses to an instruction miss is not recorded
  wire s_sel    = s_take & ~i_take;
  wire l_sel    = l_take & ~i_take;
  wire hw_need  = ~swt_on & (imiss_i | dmiss_i);
  wire [31:0] base = msw_q[`TME_MSW_IP] ? `TME_BASE_HIGH : `TME_BASE_LOW;
  // Instruction miss has priority over data misses
  wire [31:0] voff = i_take ? `TME_VEC_IMISS : (s_take ? `TME_VEC_SMISS : `TME_VEC_LMISS);

  // Packed status word and new machine state
  wire [31:0] stat_new = {16'h0000, s_sel, lru_way_i, i_take, key_i,
                          8'h00, cond_zero_i};
  wire [31:0] msw_clr  = msw_q & ~`TME_MSW_CLR_MASK;
  wire [31:0] msw_new  = {msw_clr[31:1], msw_q[`TME_MSW_ILE]};

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr     = req & wb_we_i;
  wire rd     = req & ~wb_we_i;
  // Address match per register
  wire hit_c1 = adr_hit(wb_adr_i, `TME_OFS_CFG1);
  wire hit_c2 = adr_hit(wb_adr_i, `TME_OFS_CFG2);
  wire hit_rt = adr_hit(wb_adr_i, `TME_OFS_RET);
  wire hit_st = adr_hit(wb_adr_i, `TME_OFS_STATUS);
  wire hit_ms = adr_hit(wb_adr_i, `TME_OFS_MSW);
  wire hit_is = adr_hit(wb_adr_i, `TME_OFS_IRQ_STAT);
  wire hit_im = adr_hit(wb_adr_i, `TME_OFS_IRQ_MASK);
  wire hit_vc = adr_hit(wb_adr_i, `TME_OFS_VEC);
  // Write strobes, one per writable register
  wire wr_c1  = wr & hit_c1;
  wire wr_c2  = wr & hit_c2;
  wire wr_rt  = wr & hit_rt;
  wire wr_st  = wr & hit_st;
  wire wr_ms  = wr & hit_ms;
  wire wr_im  = wr & hit_im;
  wire wr_vc  = wr & hit_vc;
  // Read of the event register clears it
  wire rd_is  = rd & hit_is;

  reg [31:0] rdata;
  // Read mux; unmapped reads return zero
  always @* begin
    rdata = `TME_ZERO32;
    case (wb_adr_i)
      `TME_OFS_CFG1:     rdata = cfg1_q;
      `TME_OFS_CFG2:     rdata = cfg2_q;
      `TME_OFS_RET:      rdata = ret_q;
      `TME_OFS_STATUS:   rdata = stat_q;
      `TME_OFS_MSW:      rdata = msw_q;
      `TME_OFS_IRQ_STAT: rdata = {29'h0, ist_q};
      `TME_OFS_IRQ_MASK: rdata = {29'h0, imask_q};
      `TME_OFS_VEC:      rdata = vec_q;
      default:           rdata = `TME_ZERO32;
    endcase
  end

  // Bus answer, one cycle after the request
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Read data stands with the answer only
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `TME_ZERO32;
    end else begin
      wb_dat_o <= rd ? rdata : `TME_ZERO32;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Lane-merged write data for the three-bit mask register
  wire [31:0] mask_wr = wmerge({29'h0, imask_q}, wb_dat_i, wb_sel_i);

  // First configuration word, holds the flash-clear bit
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg1_q <= `TME_ZERO32;
    end else if (wr_c1) begin
      cfg1_q <= wmerge(cfg1_q, wb_dat_i, wb_sel_i);
    end
  end

  // Second configuration word, search enable and way lock
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg2_q <= `TME_ZERO32;
    end else if (wr_c2) begin
      cfg2_q <= wmerge(cfg2_q, wb_dat_i, wb_sel_i);
    end
  end

  // Interrupt mask, one bit per event
  always @(posedge clk_i) begin
    if (rst_i) begin
      imask_q <= 3'h0;
    end else if (wr_im) begin
      imask_q <= mask_wr[2:0];
    end
  end

  // ****************************************************************
  // Exception entry registers, all written in the redirect cycle
  // ****************************************************************
  // Return pointer; a bus write loses to a miss in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ret_q <= `TME_ZERO32;
    end else if (any_take) begin
      ret_q <= next_pc_i;
    end else if (wr_rt) begin
      ret_q <= wmerge(ret_q, wb_dat_i, wb_sel_i);
    end
  end

  // Saved status; software may rewrite the replacement set
  always @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= `TME_ZERO32;
    end else if (any_take) begin
      stat_q <= stat_new;
    end else if (wr_st) begin
      stat_q <= wmerge(stat_q, wb_dat_i, wb_sel_i);
    end
  end

  // Machine state word, forced settings on entry
  always @(posedge clk_i) begin
    if (rst_i) begin
      msw_q <= `TME_MSW_RST;
    end else if (any_take) begin
      msw_q <= msw_new;
    end else if (wr_ms) begin
      msw_q <= wmerge(msw_q, wb_dat_i, wb_sel_i);
    end
  end

  // Last handler address, kept for software
  always @(posedge clk_i) begin
    if (rst_i) begin
      vec_q <= `TME_ZERO32;
    end else if (any_take) begin
      vec_q <= base | voff;
    end else if (wr_vc) begin
      vec_q <= wmerge(vec_q, wb_dat_i, wb_sel_i);
    end
  end

  // ****************************************************************
  // Sticky events, cleared by read; a new event wins
  // ****************************************************************
  wire [2:0] ev    = {s_sel, l_sel, i_take};
  // Next event state: read clears, a same-cycle event still lands
  wire [2:0] ist_d = (rd_is ? 3'h0 : ist_q) | ev;

  // Event register
  always @(posedge clk_i) begin
    if (rst_i) begin
      ist_q <= 3'h0;
    end else begin
      ist_q <= ist_d;
    end
  end

  // Level interrupt from the unmasked events
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(ist_d & imask_q);
    end
  end

  // ****************************************************************
  // Core-facing outputs
  // ****************************************************************
  // Hardware search request while software search is off
  always @(posedge clk_i) begin
    if (rst_i) begin
      hw_search_o <= 1'b0;
    end else begin
      hw_search_o <= hw_need;
    end
  end

  // Fetch redirect pulse, same cycle as the saved registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      redirect_o <= 1'b0;
    end else begin
      redirect_o <= any_take;
    end
  end

  // Handler address, meaningful with the redirect pulse
  always @(posedge clk_i) begin
    if (rst_i) begin
      redirect_pc_o <= `TME_ZERO32;
    end else begin
      redirect_pc_o <= base | voff;
    end
  end

  // Previous flash bit; resets to the bit's own reset level
  always @(posedge clk_i) begin
    if (rst_i) begin
      flash_prev_q <= 1'b0;
    end else begin
      flash_prev_q <= cfg1_q[`TME_CFG1_FLASH];
    end
  end

  // Falling edge of the flash bit clears every block, lock ignored
  always @(posedge clk_i) begin
    if (rst_i) begin
      flash_inv_o <= 1'b0;
    end else begin
      flash_inv_o <= flash_prev_q & ~cfg1_q[`TME_CFG1_FLASH];
    end
  end

  // Block invalidate passed on whatever the lock field says
  always @(posedge clk_i) begin
    if (rst_i) begin
      blk_inv_o     <= 1'b0;
      blk_inv_way_o <= 3'h0;
    end else begin
      blk_inv_o     <= blk_inv_i;
      blk_inv_way_o <= blk_way_i;
    end
  end

  // Registered way-lock mask for the cache
  always @(posedge clk_i) begin
    if (rst_i) begin
      way_lock_o <= `TME_ZERO8;
    end else begin
      way_lock_o <= lock_mask;
    end
  end

endmodule

// >>> testbench/tme_miss_entry_sva.sv
// ****
// Miss entry port checks
// ****
module tme_miss_entry_sva (
  input logic        clk_i,
  input logic        rst_i,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_ack_o,
  input logic        imiss_i,
  input logic        dmiss_i,
  input logic        dstore_i,
  input logic        dchg_i,
  input logic        blk_inv_i,
  input logic [2:0]  blk_way_i,
  input logic        hw_search_o,
  input logic        redirect_o,
  input logic [31:0] redirect_pc_o,
  input logic        blk_inv_o,
  input logic [2:0]  blk_inv_way_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answer timing
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  // Miss outcomes
  one_path_a: assert property (!(redirect_o && hw_search_o))
    else $error("hardware and software search together");
  redir_cause_a: assert property (redirect_o |-> $past(imiss_i || dmiss_i || dchg_i && dstore_i))
    else $error("redirect without a miss");
  ivec_a: assert property (redirect_o && $past(imiss_i) |-> redirect_pc_o[15:0] == 16'h1000)
    else $error("wrong instruction miss vector");
  lvec_a: assert property (redirect_o && $past(!imiss_i && dmiss_i && !dstore_i)
    |-> redirect_pc_o[15:0] == 16'h1100)
    else $error("wrong load miss vector");
  svec_a: assert property (redirect_o && $past(!imiss_i && dstore_i && (dmiss_i || dchg_i))
    |-> redirect_pc_o[15:0] == 16'h1200)
    else $error("wrong store miss vector");
  vec_base_a: assert property (redirect_o |-> redirect_pc_o[31:20] inside {12'h000, 12'hFFF})
    else $error("handler base not a legal base");
  blk_copy_a: assert property (blk_inv_i |=> blk_inv_o && blk_inv_way_o == $past(blk_way_i))
    else $error("block invalidate not passed on");
endmodule

// >>> testbench/tme_miss_entry_tb.sv
module tme_miss_entry_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, cyc, stb, we, imiss, dmiss, dst, dchg, key, lru, binv;
  logic        ack, hws, red, fli, bio, irq;
  logic [5:0]  adr;
  logic [3:0]  cond;
  logic [2:0]  bway, bwo;
  logic [7:0]  wlk;
  logic [31:0] wdat, rdat, npc, pc_o;
  logic [31:0] rq[$], pq[$];
  int          err_count, checked;
  logic        abort;
  tme_miss_entry uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .imiss_i(imiss), .dmiss_i(dmiss), .dstore_i(dst), .dchg_i(dchg),
    .next_pc_i(npc), .cond_zero_i(cond), .key_i(key), .lru_way_i(lru), .blk_inv_i(binv),
    .blk_way_i(bway), .hw_search_o(hws), .redirect_o(red), .redirect_pc_o(pc_o),
    .flash_inv_o(fli), .blk_inv_o(bio), .blk_inv_way_o(bwo), .way_lock_o(wlk), .irq_o(irq));
  // ****
  // Helpers
  // ****
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    if (abort) return;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      err_count++;
      $display("FAIL bus_ack exp 1 got %b", ack);
      abort = 1'b1;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Result watcher against noted expectations
  always @(posedge clk_i) begin
    if (ack && cyc && !we) chk("rdata", rq.pop_front(), rdat);
    if (red) chk("vector", pq.pop_front(), pc_o);
  end
  // ****
  // Main sequence
  // ****
  initial begin
    logic [31:0] r, v;
    int n;
    {rst_i, cyc, stb, we, imiss, dmiss, dst, dchg, key, lru, binv} = 11'h400;
    {adr, cond, bway, wdat, npc} = '0;
    err_count = 0;
    checked = 0;
    abort = 1'b0;
    void'($urandom(32'h7826));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(6'h10, 32'h0000_0040);
    rd(6'h04, 32'h0);
    rd(6'h20, 32'h0);
    @(posedge clk_i);
    imiss <= 1'b1;
    @(posedge clk_i);
    imiss <= 1'b0;
    @(posedge clk_i);
    chk("hw_search", 32'h1, {31'h0, hws});
    $display("reset and hardware search done");
    bus(1'b1, 6'h04, 32'h0000_1000);
    for (int t = 0; t < 4; t++) begin
      r = $urandom;
      v = $urandom;
      bus(1'b1, 6'h18, {29'h0, {3{t != 3}}});
      bus(1'b1, 6'h10, r);
      pq.push_back((r[6] ? 32'hFFF0_0000 : 32'h0) | (t == 0 ? 32'h1000 :
        t == 1 ? 32'h1100 : 32'h1200));
      @(posedge clk_i);
      {imiss, dmiss, dst, dchg} <= {t == 0, t == 1 || t == 2, t >= 2, t == 3};
      {npc, cond, key, lru} <= {v, v[3:0], v[4], v[5]};
      @(posedge clk_i);
      {imiss, dmiss, dst, dchg} <= 4'h0;
      @(posedge clk_i);
      chk("irq", {31'h0, t != 3}, {31'h0, irq});
      rd(6'h08, v);
      rd(6'h0C, {16'h0, t >= 2, v[5], t == 0, v[4], 8'h0, v[3:0]});
      rd(6'h10, (r & ~32'h0006_EF32 & ~32'h1) | r[16]);
      rd(6'h14, 32'h1 << (t == 0 ? 0 : t == 1 ? 1 : 2));
      rd(6'h14, 32'h0);
      repeat (2) @(posedge clk_i);
      chk("irq", 32'h0, {31'h0, irq});
    end
    bus(1'b1, 6'h0C, 32'h0000_4000);
    rd(6'h0C, 32'h0000_4000);
    $display("software miss entry done");
    for (n = 0; n < 8; n++) begin
      bus(1'b1, 6'h04, n << 16);
      repeat (2) @(posedge clk_i);
      chk("way_lock", n == 7 ? 0 : (1 << n) - 1, {24'h0, wlk});
    end
    bus(1'b1, 6'h00, 32'h0010_0000);
    bus(1'b1, 6'h00, 32'h0);
    n = 0;
    while (fli !== 1'b1 && n < 5) begin
      @(posedge clk_i);
      n++;
    end
    chk("flash", 32'h1, {31'h0, fli});
    bus(1'b1, 6'h04, 32'h0006_0000);
    @(posedge clk_i);
    binv <= 1'b1;
    bway <= 3'h5;
    @(posedge clk_i);
    binv <= 1'b0;
    @(posedge clk_i);
    chk("blk_inv", 32'hD, {28'h0, bio, bwo});
    $display("cache invalidate done");
    chk("pending", 32'h0, rq.size() + pq.size());
    summarize();
  end
endmodule

bind tme_miss_entry tme_miss_entry_sva chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .imiss_i(imiss_i),
  .dmiss_i(dmiss_i), .dstore_i(dstore_i), .dchg_i(dchg_i), .blk_inv_i(blk_inv_i),
  .blk_way_i(blk_way_i), .hw_search_o(hw_search_o), .redirect_o(redirect_o),
  .redirect_pc_o(redirect_pc_o), .blk_inv_o(blk_inv_o), .blk_inv_way_o(blk_inv_way_o));
